// ---- tb/sptl_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Front end of the source: regulation flags and terminal voltage
module sptl_source_model (
  input wire logic clock_i,
  input wire logic [5:0] flags_req_i,
  input wire logic [15:0] ext_volt_i,
  input wire logic [15:0] volt_set_i,
  input wire logic output_enable_i,
  output logic [5:0] flags_o,
  output logic [15:0] meas_volt_o
);
  always_ff @(posedge clock_i) begin
    flags_o <= flags_req_i;
  end
  // Disabled output falls to zero, a forced external voltage stays
  assign meas_volt_o = (output_enable_i ? volt_set_i : 16'h0000) + ext_volt_i;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic trigger_i = 1'b0;
  logic [5:0] flag_req = 6'h00;
  logic [15:0] ext_volt = 16'h0000;
  logic [15:0] rdata_o;
  logic summary;
  logic tripped;
  logic out_en;
  logic awaiting;
  logic [15:0] vset;
  logic [15:0] cset;
  logic [5:0] src_flags;
  logic [15:0] meas_volt;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 clock_i = ~clock_i;

  sptl_source_model src_u (.clock_i(clock_i), .flags_req_i(flag_req), .ext_volt_i(ext_volt),
    .volt_set_i(vset), .output_enable_i(out_en), .flags_o(src_flags), .meas_volt_o(meas_volt));

  sptl_status_block dut_u (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .calibrating_i(src_flags[0]),
    .main_const_voltage_flag_i(src_flags[1]), .aux_const_voltage_flag_i(src_flags[2]),
    .positive_const_current_flag_i(src_flags[3]), .negative_const_current_flag_i(src_flags[4]),
    .aux_const_current_flag_i(src_flags[5]), .meas_volt_i(meas_volt), .trigger_i(trigger_i),
    .operation_summary_bit_o(summary), .overvoltage_tripped_bit_o(tripped),
    .output_enable_o(out_en), .awaiting_trigger_flag_o(awaiting), .volt_set_o(vset),
    .curr_set_o(cset));

  task automatic give_verdict;
    $display("Checks %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, rdata_o, exp);
  endtask

  task automatic pulse_trigger;
    @(posedge clock_i);
    trigger_i <= 1'b1;
    @(posedge clock_i);
    trigger_i <= 1'b0;
    step(1);
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rd("rise", 8'h0C, 16'h7FFF);
    rd("fall", 8'h10, 16'h0000);
    rd("enable", 8'h08, 16'h0000);
    rd("cond", 8'h00, 16'h0000);
    rd("level", 8'h18, 16'hFFFF);
    rd("vimm", 8'h1C, 16'h0000);
    rd("unmapped", 8'hFC, 16'h0000);
    wr(8'h08, 16'hFFFF);
    rd("enable", 8'h08, 16'h7FFF);
    wr(8'h00, 16'hFFFF);
    rd("cond", 8'h00, 16'h0000);
    wr(8'h0C, 16'h0100);
    wr(8'h10, 16'h0200);
    wr(8'h08, 16'h0000);
    @(posedge clock_i) flag_req <= 6'b000011;
    step(8);
    rd("cond", 8'h00, 16'h0101);
    rd("event", 8'h04, 16'h0100);
    @(posedge clock_i) flag_req <= 6'b000111;
    step(8);
    rd("event", 8'h04, 16'h0000);
    @(posedge clock_i) flag_req <= 6'b000001;
    step(8);
    rd("event", 8'h04, 16'h0200);
    rd("event", 8'h04, 16'h0000);
    wr(8'h0C, 16'h7FFF);
    wr(8'h10, 16'h7FFF);
    @(posedge clock_i) flag_req <= 6'b111110;
    step(8);
    rd("cond", 8'h00, 16'h1F00);
    chk("summary", {15'h0000, summary}, 16'h0000);
    wr(8'h08, 16'h0001);
    step(1);
    chk("summary", {15'h0000, summary}, 16'h0001);
    rd("event", 8'h04, 16'h1F01);
    step(1);
    chk("summary", {15'h0000, summary}, 16'h0000);
    wr(8'h1C, 16'h0080);
    wr(8'h18, 16'h0100);
    @(posedge clock_i) ext_volt <= 16'h0181;
    step(2);
    chk("trip", {15'h0000, tripped}, 16'h0000);
    @(posedge clock_i) ext_volt <= 16'h0080;
    wr(8'h14, 16'h0001);
    step(1);
    chk("trip", {15'h0000, tripped}, 16'h0000);
    rd("ctrl", 8'h14, 16'h0005);
    @(posedge clock_i) ext_volt <= 16'h0181;
    step(1);
    chk("trip", {15'h0000, tripped}, 16'h0001);
    chk("out_en", {15'h0000, out_en}, 16'h0000);
    rd("ctrl", 8'h14, 16'h0003);
    wr(8'h2C, 16'h0008);
    step(2);
    chk("trip", {15'h0000, tripped}, 16'h0001);
    @(posedge clock_i) ext_volt <= 16'h0000;
    wr(8'h2C, 16'h0008);
    step(1);
    chk("trip", {15'h0000, tripped}, 16'h0000);
    chk("out_en", {15'h0000, out_en}, 16'h0001);
    wr(8'h14, 16'h0000);
    wr(8'h20, 16'h0321);
    wr(8'h28, 16'h0456);
    pulse_trigger();
    chk("vset", vset, 16'h0080);
    wr(8'h2C, 16'h0004);
    step(1);
    chk("await", {15'h0000, awaiting}, 16'h0001);
    rd("cond", 8'h00, 16'h1F20);
    pulse_trigger();
    step(1);
    chk("vset", vset, 16'h0321);
    chk("cset", cset, 16'h0456);
    chk("await", {15'h0000, awaiting}, 16'h0000);
    wr(8'h2C, 16'h0002);
    step(1);
    chk("vset", vset, 16'h0000);
    rd("vtrig", 8'h20, 16'h0000);
    wr(8'h24, 16'h0222);
    rd("cimm", 8'h24, 16'h0222);
    rd("ctrig", 8'h28, 16'h1999);
    wr(8'h08, 16'h0123);
    wr(8'h10, 16'h0456);
    wr(8'h0C, 16'h0001);
    wr(8'h2C, 16'h0001);
    rd("rise", 8'h0C, 16'h7FFF);
    rd("fall", 8'h10, 16'h0000);
    rd("enable", 8'h08, 16'h0000);
    @(posedge clock_i) flag_req <= 6'b000001;
    repeat (3) @(posedge clock_i);
    rd("event", 8'h04, 16'h0020);
    rd("event", 8'h04, 16'h0001);
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- verilog/sptl_pkg.sv ----
// Function
// - Operation group has condition, enable, event, rise filter and fall filter registers.
// - Preset sets defined rise filter bits, clears fall filter and enable registers.
// - Condition register is read-only and shows the live operating state.
// - Event register is read-only and latches filtered transitions until cleared.
// - Reading the event register returns its contents, then clears it.
// - Summary bit is the OR of enabled event bits.
// - Enable mask takes 0 to 32767, reads back, and preset leaves zero.
// - Bit 0 shows calibration constants being computed.
// - Bit 5 shows the source waiting for a trigger.
// - Bits 8 and 9 show constant voltage on main and auxiliary outputs.
// - Bits 10, 11, 12 show positive, negative and auxiliary constant current.
// - Enabled overvoltage guard over the level disables output, sets tripped bit.
// - Overvoltage trip acts at once, without the protection delay.
// - Protection clear works only once the overvoltage cause is gone.
// - Overvoltage guard has writable on/off state and level resetting to maximum.
// - Pending levels move to output only on trigger while initiated.
// - Command reset returns pending and immediate voltage levels to zero.
// - Rise filter passes 0-to-1, fall filter passes 1-to-0 condition changes.
// - After preset fall filter holds zero, rise filter holds 32767.
package sptl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFF_COND = 8'h00;
  localparam logic [7:0] OFF_EVENT = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_RISE = 8'h0C;
  localparam logic [7:0] OFF_FALL = 8'h10;
  localparam logic [7:0] OFF_OVP_CTRL = 8'h14;
  localparam logic [7:0] OFF_OVP_LEVEL = 8'h18;
  localparam logic [7:0] OFF_VOLT_IMM = 8'h1C;
  localparam logic [7:0] OFF_VOLT_TRIG = 8'h20;
  localparam logic [7:0] OFF_CURR_IMM = 8'h24;
  localparam logic [7:0] OFF_CURR_TRIG = 8'h28;
  localparam logic [7:0] OFF_CMD = 8'h2C;
  localparam int BIT_CAL = 0;
  localparam int BIT_WTG = 5;
  localparam int BIT_CV = 8;
  localparam int BIT_CV2 = 9;
  localparam int BIT_CCP = 10;
  localparam int BIT_CCN = 11;
  localparam int BIT_CC2 = 12;
  localparam logic [15:0] OPERATION_SUMMARY_BIT_MASK = 16'h1F21;
  localparam logic [15:0] FILTER_MASK = 16'h7FFF;
  localparam logic [15:0] RISE_PRESET = 16'h7FFF;
  localparam logic [15:0] FALL_PRESET = 16'h0000;
  localparam logic [15:0] ENABLE_PRESET = 16'h0000;
  localparam logic [15:0] OVP_LEVEL_RST = 16'hFFFF;
  localparam logic [15:0] VOLT_RST = 16'h0000;
  localparam logic [15:0] CURR_RST = 16'h1999;
  localparam int CMD_PRESET = 0;
  localparam int CMD_RESET = 1;
  localparam int CMD_INIT = 2;
  localparam int CMD_CLEAR = 3;
  localparam int CTRL_OVP_ON = 0;
  localparam int CTRL_TRIPPED = 1;
  localparam int CTRL_OUT_EN = 2;
  localparam int CTRL_INIT = 3;
endpackage

// ---- verilog/sptl_status_block.sv ----
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sptl_status_block (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic calibrating_i,
  input wire logic main_const_voltage_flag_i,
  input wire logic aux_const_voltage_flag_i,
  input wire logic positive_const_current_flag_i,
  input wire logic negative_const_current_flag_i,
  input wire logic aux_const_current_flag_i,
  input wire logic [15:0] meas_volt_i,
  input wire logic trigger_i,
  output logic operation_summary_bit_o,
  output logic overvoltage_tripped_bit_o,
  output logic output_enable_o,
  output logic awaiting_trigger_flag_o,
  output logic [15:0] volt_set_o,
  output logic [15:0] curr_set_o
);

  // Status pins come from the analog side, so each gets two flops
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  wire [5:0] raw_flags = {aux_const_current_flag_i, negative_const_current_flag_i,
    positive_const_current_flag_i, aux_const_voltage_flag_i,
    main_const_voltage_flag_i, calibrating_i};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= raw_flags[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic [15:0] operation_condition;
  logic [15:0] cond_prev;
  logic [15:0] operation_event_latch;
  logic [15:0] operation_enable_mask;
  logic [15:0] operation_rise_filter;
  logic [15:0] operation_fall_filter;
  logic overvoltage_guard;
  logic [15:0] ovp_level;
  logic tripped;
  logic initiated;
  logic [15:0] volt_trig;
  logic [15:0] curr_trig;

  // Command decode
  wire wr_cmd = wr_i && (addr_i == sptl_pkg::OFF_CMD);
  wire cmd_preset = wr_cmd && wdata_i[sptl_pkg::CMD_PRESET];
  wire cmd_reset = rst_i || (wr_cmd && wdata_i[sptl_pkg::CMD_RESET]);
  wire cmd_init = wr_cmd && wdata_i[sptl_pkg::CMD_INIT];
  wire cmd_clear = wr_cmd && wdata_i[sptl_pkg::CMD_CLEAR];
  wire wr_enable = wr_i && (addr_i == sptl_pkg::OFF_ENABLE);
  wire wr_rise = wr_i && (addr_i == sptl_pkg::OFF_RISE);
  wire wr_fall = wr_i && (addr_i == sptl_pkg::OFF_FALL);
  wire wr_ctrl = wr_i && (addr_i == sptl_pkg::OFF_OVP_CTRL);
  wire wr_level = wr_i && (addr_i == sptl_pkg::OFF_OVP_LEVEL);
  wire wr_vimm = wr_i && (addr_i == sptl_pkg::OFF_VOLT_IMM);
  wire wr_vtrig = wr_i && (addr_i == sptl_pkg::OFF_VOLT_TRIG);
  wire wr_cimm = wr_i && (addr_i == sptl_pkg::OFF_CURR_IMM);
  wire wr_ctrig = wr_i && (addr_i == sptl_pkg::OFF_CURR_TRIG);
  wire rd_event = rd_i && (addr_i == sptl_pkg::OFF_EVENT);

  // Live condition word; unused positions forced low
  wire [15:0] next_cond = {3'h0, sync_b[5:1], 2'h0, initiated, 4'h0, sync_b[0]}
    & sptl_pkg::OPERATION_SUMMARY_BIT_MASK;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      operation_condition <= 16'h0000;
      cond_prev <= 16'h0000;
    end else begin
      operation_condition <= next_cond;
      cond_prev <= operation_condition;
    end
  end

  // Transition filters
  wire [15:0] rise_hits = operation_condition & ~cond_prev & operation_rise_filter;
  wire [15:0] fall_hits = ~operation_condition & cond_prev & operation_fall_filter;
  wire [15:0] hits = (rise_hits | fall_hits) & sptl_pkg::OPERATION_SUMMARY_BIT_MASK;

  // Clearing read and new events: the set wins
  wire [15:0] next_event = (rd_event ? 16'h0000 : operation_event_latch) | hits;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      operation_event_latch <= 16'h0000;
    end else begin
      operation_event_latch <= next_event;
    end
  end

  // Mask and filters; preset overrides a write in the same cycle
  wire [15:0] next_enable = (rst_i || cmd_preset) ? sptl_pkg::ENABLE_PRESET :
    wr_enable ? (wdata_i & sptl_pkg::FILTER_MASK) : operation_enable_mask;

  // Summary computed from next values so the flop matches the latch
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      operation_summary_bit_o <= 1'b0;
    end else begin
      operation_summary_bit_o <= |(next_event & next_enable);
    end
  end

  always_ff @(posedge clock_i) begin
    operation_enable_mask <= next_enable;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || cmd_preset) begin
      operation_rise_filter <= sptl_pkg::RISE_PRESET;
      operation_fall_filter <= sptl_pkg::FALL_PRESET;
    end else begin
      if (wr_rise) begin
        operation_rise_filter <= wdata_i & sptl_pkg::FILTER_MASK;
      end
      if (wr_fall) begin
        operation_fall_filter <= wdata_i & sptl_pkg::FILTER_MASK;
      end
    end
  end

  // Overvoltage guard settings
  always_ff @(posedge clock_i) begin
    if (cmd_reset) begin
      overvoltage_guard <= 1'b0;
      ovp_level <= sptl_pkg::OVP_LEVEL_RST;
    end else begin
      if (wr_ctrl) begin
        overvoltage_guard <= wdata_i[sptl_pkg::CTRL_OVP_ON];
      end
      if (wr_level) begin
        ovp_level <= wdata_i;
      end
    end
  end

  // Trip compares every cycle with no hold-off; the latch survives a
  // clear while the voltage is still above the level
  wire over_level = meas_volt_i > ovp_level;
  wire trip_now = overvoltage_guard && over_level;
  wire clear_ok = cmd_clear && !over_level;
  wire next_tripped = trip_now || (tripped && !clear_ok);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tripped <= 1'b0;
      overvoltage_tripped_bit_o <= 1'b0;
      output_enable_o <= 1'b1;
    end else begin
      tripped <= next_tripped;
      overvoltage_tripped_bit_o <= next_tripped;
      output_enable_o <= !next_tripped;
    end
  end

  // Trigger system
  wire fire = trigger_i && initiated;

  always_ff @(posedge clock_i) begin
    if (cmd_reset) begin
      initiated <= 1'b0;
      awaiting_trigger_flag_o <= 1'b0;
    end else begin
      initiated <= cmd_init || (initiated && !trigger_i);
      awaiting_trigger_flag_o <= cmd_init || (initiated && !trigger_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (cmd_reset) begin
      volt_set_o <= sptl_pkg::VOLT_RST;
      volt_trig <= sptl_pkg::VOLT_RST;
      curr_set_o <= sptl_pkg::CURR_RST;
      curr_trig <= sptl_pkg::CURR_RST;
    end else begin
      if (fire) begin
        volt_set_o <= volt_trig;
        curr_set_o <= curr_trig;
      end else begin
        if (wr_vimm) begin
          volt_set_o <= wdata_i;
        end
        if (wr_cimm) begin
          curr_set_o <= wdata_i;
        end
      end
      if (wr_vtrig) begin
        volt_trig <= wdata_i;
      end
      if (wr_ctrig) begin
        curr_trig <= wdata_i;
      end
    end
  end

  // Read path
  wire [15:0] ctrl_word = {12'h000, initiated, !tripped, tripped, overvoltage_guard};
  logic [15:0] read_mux;

  always_comb begin
    unique case (addr_i)
      sptl_pkg::OFF_COND: read_mux = operation_condition;
      sptl_pkg::OFF_EVENT: read_mux = operation_event_latch;
      sptl_pkg::OFF_ENABLE: read_mux = operation_enable_mask;
      sptl_pkg::OFF_RISE: read_mux = operation_rise_filter;
      sptl_pkg::OFF_FALL: read_mux = operation_fall_filter;
      sptl_pkg::OFF_OVP_CTRL: read_mux = ctrl_word;
      sptl_pkg::OFF_OVP_LEVEL: read_mux = ovp_level;
      sptl_pkg::OFF_VOLT_IMM: read_mux = volt_set_o;
      sptl_pkg::OFF_VOLT_TRIG: read_mux = volt_trig;
      sptl_pkg::OFF_CURR_IMM: read_mux = curr_set_o;
      sptl_pkg::OFF_CURR_TRIG: read_mux = curr_trig;
      default: read_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= read_mux;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  event_clear_a: assert property (rd_event && hits == 16'h0000 |=> operation_event_latch == 16'h0000)
    else $error("event register not cleared by read");
  event_read_a: assert property (rd_event |=> rdata_o == $past(operation_event_latch))
    else $error("event read returned wrong value");
  event_hold_a: assert property (!rd_event && hits == 16'h0000 |=> $stable(operation_event_latch))
    else $error("event register changed without cause");
  read_set_wins_a: assert property (rd_event && hits != 16'h0000 |=>
    (operation_event_latch & $past(hits)) == $past(hits))
    else $error("event lost during clearing read");
  summary_or_a: assert property (operation_summary_bit_o ==
    (|(operation_event_latch & operation_enable_mask)))
    else $error("summary bit disagrees with enabled events");
  preset_values_a: assert property (cmd_preset && !cmd_reset |=>
    operation_rise_filter == sptl_pkg::RISE_PRESET && operation_fall_filter == sptl_pkg::FALL_PRESET &&
    operation_enable_mask == sptl_pkg::ENABLE_PRESET)
    else $error("preset left wrong filter or mask values");
  ovp_trip_a: assert property (overvoltage_guard && over_level |=>
    overvoltage_tripped_bit_o && !output_enable_o)
    else $error("overvoltage did not trip in one cycle");
  ovp_hold_a: assert property (tripped && over_level |=> tripped && !output_enable_o)
    else $error("trip cleared while still over level");
  trig_copy_a: assert property (trigger_i && initiated && !cmd_reset |=>
    volt_set_o == $past(volt_trig) && curr_set_o == $past(curr_trig))
    else $error("trigger did not move pending levels");
  no_trig_a: assert property (!initiated && !wr_vimm && !cmd_reset |=> $stable(volt_set_o))
    else $error("output level moved without initiated trigger");
  cmd_reset_a: assert property (wr_cmd && wdata_i[sptl_pkg::CMD_RESET] |=>
    volt_set_o == sptl_pkg::VOLT_RST && volt_trig == sptl_pkg::VOLT_RST)
    else $error("command reset left voltage levels nonzero");
  unused_zero_a: assert property ((operation_condition & 16'hE0DE) == 16'h0000 &&
    (operation_event_latch & 16'hE0DE) == 16'h0000)
    else $error("unused status bit set");
  rise_event_a: assert property (operation_condition[8] && !cond_prev[8] &&
    operation_rise_filter[8] |=> operation_event_latch[8])
    else $error("filtered rise missed");

  // Condition word bit map
  cal_map_a: assert property (operation_condition[sptl_pkg::BIT_CAL] == $past(sync_b[0]))
    else $error("calibration bit does not follow its pin");
  wait_map_a: assert property (operation_condition[sptl_pkg::BIT_WTG] == $past(initiated))
    else $error("waiting bit does not follow trigger state");
  volt_map_a: assert property (operation_condition[sptl_pkg::BIT_CV] == $past(sync_b[1]) &&
    operation_condition[sptl_pkg::BIT_CV2] == $past(sync_b[2]))
    else $error("constant voltage bits do not follow pins");
  curr_map_a: assert property (operation_condition[sptl_pkg::BIT_CCP] == $past(sync_b[3]) &&
    operation_condition[sptl_pkg::BIT_CCN] == $past(sync_b[4]) &&
    operation_condition[sptl_pkg::BIT_CC2] == $past(sync_b[5]))
    else $error("constant current bits do not follow pins");

  // Filters, mask and register reads
  fall_event_a: assert property (!operation_condition[sptl_pkg::BIT_CV2] && cond_prev[sptl_pkg::BIT_CV2] &&
    operation_fall_filter[sptl_pkg::BIT_CV2] |=> operation_event_latch[sptl_pkg::BIT_CV2])
    else $error("filtered fall missed");
  enable_write_a: assert property (wr_enable && !cmd_preset |=>
    operation_enable_mask == ($past(wdata_i) & sptl_pkg::FILTER_MASK))
    else $error("enable mask write not stored");
  enable_width_a: assert property (!operation_enable_mask[15])
    else $error("enable mask bit 15 set");
  rise_write_a: assert property (wr_rise |=>
    operation_rise_filter == ($past(wdata_i) & sptl_pkg::FILTER_MASK))
    else $error("rise filter write not stored");
  fall_write_a: assert property (wr_fall |=>
    operation_fall_filter == ($past(wdata_i) & sptl_pkg::FILTER_MASK))
    else $error("fall filter write not stored");
  cond_read_a: assert property (rd_i && addr_i == sptl_pkg::OFF_COND |=>
    rdata_o == $past(operation_condition))
    else $error("condition read returned wrong value");
  enable_read_a: assert property (rd_i && addr_i == sptl_pkg::OFF_ENABLE |=>
    rdata_o == $past(operation_enable_mask))
    else $error("enable read returned wrong value");
  rise_read_a: assert property (rd_i && addr_i == sptl_pkg::OFF_RISE |=>
    rdata_o == $past(operation_rise_filter))
    else $error("rise filter read returned wrong value");
  fall_read_a: assert property (rd_i && addr_i == sptl_pkg::OFF_FALL |=>
    rdata_o == $past(operation_fall_filter))
    else $error("fall filter read returned wrong value");
  read_idle_a: assert property (!rd_i |=>
    rdata_o == 16'h0000)
    else $error("read data stood outside its cycle");

  // Overvoltage guard
  guard_write_a: assert property (wr_ctrl && !cmd_reset |=>
    overvoltage_guard == $past(wdata_i[sptl_pkg::CTRL_OVP_ON]))
    else $error("guard state write not stored");
  level_write_a: assert property (wr_level && !cmd_reset |=>
    ovp_level == $past(wdata_i))
    else $error("protection level write not stored");
  level_reset_a: assert property (cmd_reset |=>
    ovp_level == sptl_pkg::OVP_LEVEL_RST && !overvoltage_guard)
    else $error("command reset left guard settings");
  guard_off_a: assert property (!overvoltage_guard && !tripped |=>
    !overvoltage_tripped_bit_o)
    else $error("trip while guard off");
  no_delay_a: assert property (overvoltage_guard && $rose(over_level) |=>
    overvoltage_tripped_bit_o)
    else $error("trip delayed");
  clear_ok_a: assert property (tripped && cmd_clear && !over_level |=>
    !overvoltage_tripped_bit_o && output_enable_o)
    else $error("protection clear refused");
  out_en_match_a: assert property (output_enable_o == !overvoltage_tripped_bit_o)
    else $error("output enable disagrees with trip bit");

  // Trigger and pending levels
  await_set_a: assert property (cmd_init && !cmd_reset |=>
    awaiting_trigger_flag_o && initiated)
    else $error("initiate did not raise waiting flag");
  await_drop_a: assert property (fire && !cmd_init |=>
    !awaiting_trigger_flag_o)
    else $error("trigger did not end waiting");
  volt_hold_a: assert property (!fire && !cmd_reset && !wr_vimm |=>
    $stable(volt_set_o))
    else $error("voltage setting moved without cause");
  curr_hold_a: assert property (!fire && !cmd_reset && !wr_cimm |=>
    $stable(curr_set_o))
    else $error("current setting moved without cause");
  vpend_write_a: assert property (wr_vtrig && !cmd_reset |=>
    volt_trig == $past(wdata_i))
    else $error("pending voltage write not stored");
  cpend_write_a: assert property (wr_ctrig && !cmd_reset |=>
    curr_trig == $past(wdata_i))
    else $error("pending current write not stored");

  trip_c: cover property (trip_now ##1 tripped ##[1:20] !tripped);
  fire_c: cover property (cmd_init ##[1:10] fire);
  read_set_c: cover property (rd_event && hits != 16'h0000);
  summary_c: cover property ($rose(operation_summary_bit_o));
  clear_c: cover property (tripped && cmd_clear && !over_level);

endmodule
`default_nettype wire
